// ---- hw/sdc_divider_config_regs.sv ----
// Divider configuration word bank behind an AXI4-Lite slave
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "sdc_regs_cfg.svh"

// What this block does
// - Word 0x1d resets to 18c6; host must overwrite it with zero.
// - Word 0x1e resets to 18c6; host must overwrite it with 18a6.
// - Device reset bit restores every word to its reset value.
// - Divide count bits 18..16 in word 0x22 bits 2..0; rest held 2.
// - Divide count bits 15..0 fill word 0x24, reset 0028.
// - Word 0x25 bit 15 enables the fractional seed, reset zero.
// - Word 0x26 resets to all ones.
// - Enabled seed sets the modulator starting state.
module sdc_divider_config_regs #(
  parameter int ADDR_W = 12,
  parameter int SEED_W = 32
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Fractional engine
  input  wire logic              modulator_restart,
  input  wire logic [SEED_W-1:0] fraction_seed_value,
  output logic [SEED_W-1:0]      modulator_start_state,
  // Configuration outputs
  output logic [18:0]            feedback_divide_count,
  output logic [5:0]             phase_detector_delay_select,
  output logic                   fraction_seed_enable,
  output logic [15:0]            denominator_upper_word
);
  sdc_reg_if bus_if ();

  sdc_pkg::sdc_word_t words      [0:`SDC_NUM_WORDS-1];
  sdc_pkg::sdc_word_t next_words [0:`SDC_NUM_WORDS-1];
  logic               pending, next_pending;
  logic               soft_reset;
  logic               seeded;

  ////////////////////////////////////////////////////////////////////////////
  function automatic sdc_pkg::sdc_word_t reset_word(input sdc_pkg::sdc_slot_t s);
    case (s)
      4'h0:    reset_word = `SDC_RST_18;
      4'h1:    reset_word = `SDC_RST_19;
      4'h2:    reset_word = `SDC_RST_1A;
      4'h3:    reset_word = `SDC_RST_1B;
      4'h4:    reset_word = `SDC_RST_1C;
      4'h5:    reset_word = `SDC_RST_1D;
      4'h6:    reset_word = `SDC_RST_1E;
      4'h7:    reset_word = `SDC_RST_1F;
      4'h8:    reset_word = `SDC_RST_20;
      4'h9:    reset_word = `SDC_RST_21;
      4'ha:    reset_word = `SDC_RST_22;
      4'hb:    reset_word = `SDC_RST_23;
      4'hc:    reset_word = `SDC_RST_24;
      4'hd:    reset_word = `SDC_RST_25;
      4'he:    reset_word = `SDC_RST_26;
      default: reset_word = 16'h0000;
    endcase
  endfunction : reset_word

  function automatic logic in_bank(input sdc_pkg::sdc_idx_t idx);
    in_bank = (idx >= `SDC_IDX_18) && (idx <= `SDC_IDX_26);
  endfunction : in_bank

  function automatic sdc_pkg::sdc_slot_t slot(input sdc_pkg::sdc_idx_t idx);
    sdc_pkg::sdc_idx_t d;
    d    = idx - `SDC_IDX_18;
    slot = d[3:0];
  endfunction : slot

  function automatic sdc_pkg::sdc_word_t merge(input sdc_pkg::sdc_word_t old,
                                               input sdc_pkg::sdc_word_t data,
                                               input logic [1:0]         strb);
    merge[7:0]  = strb[0] ? data[7:0]  : old[7:0];
    merge[15:8] = strb[1] ? data[15:8] : old[15:8];
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  sdc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (bus_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Device reset bit self-clears: it acts once and reads back as zero
  assign soft_reset = bus_if.wr_en && (bus_if.wr_idx == `SDC_IDX_CTRL) &&
                      bus_if.wr_strb[0] && bus_if.wr_data[`SDC_CTRL_RESET_BIT];

  // Status is read-only, so a write to it draws an error response
  assign bus_if.wr_ok = in_bank(bus_if.wr_idx) || (bus_if.wr_idx == `SDC_IDX_CTRL);

  always_comb begin
    next_words   = words;
    next_pending = pending;
    if (soft_reset) begin
      for (int i = 0; i < `SDC_NUM_WORDS; i++) begin
        next_words[i] = reset_word(4'(i));
      end
      next_pending = 1'b0;
    end else if (bus_if.wr_en && in_bank(bus_if.wr_idx)) begin
      // Reserved fields store what the host writes; no masking is applied
      next_words[slot(bus_if.wr_idx)] = merge(words[slot(bus_if.wr_idx)],
                                              bus_if.wr_data, bus_if.wr_strb);
      if (bus_if.wr_idx == `SDC_IDX_22) begin
        next_pending = 1'b1;
      end else if (bus_if.wr_idx == `SDC_IDX_24) begin
        next_pending = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `SDC_NUM_WORDS; i++) begin
        words[i] <= reset_word(4'(i));
      end
      pending <= 1'b0;
    end else begin
      words   <= next_words;
      pending <= next_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    bus_if.rd_ok   = 1'b1;
    bus_if.rd_data = 16'h0000;
    if (in_bank(bus_if.rd_idx)) begin
      bus_if.rd_data = words[slot(bus_if.rd_idx)];
    end else if (bus_if.rd_idx == `SDC_IDX_CTRL) begin
      bus_if.rd_data = 16'h0000;
    end else if (bus_if.rd_idx == `SDC_IDX_STATUS) begin
      bus_if.rd_data = {14'h0000, seeded, pending};
    end else begin
      bus_if.rd_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The count follows each half as it lands; a half-written pair is visible
  assign feedback_divide_count = {words[slot(`SDC_IDX_22)][`SDC_UPPER_MSB:0],
                                  words[slot(`SDC_IDX_24)]};
  assign phase_detector_delay_select =
    words[slot(`SDC_IDX_25)][`SDC_DLY_MSB:`SDC_DLY_LSB];
  assign fraction_seed_enable   = words[slot(`SDC_IDX_25)][`SDC_SEED_EN_BIT];
  assign denominator_upper_word = words[slot(`SDC_IDX_26)];

  sdc_seed_engine #(
    .SEED_W (SEED_W)
  ) u_seed (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .restart     (modulator_restart),
    .seed_enable (fraction_seed_enable),
    .seed_value  (fraction_seed_value),
    .start_state (modulator_start_state),
    .seeded      (seeded)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_reset_1d;
    @(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> words[slot(`SDC_IDX_1D)] == 16'h18c6;
  endproperty
  a_reset_1d: assert property (p_reset_1d) else $error("word 1d reset wrong");

  property p_reset_1e;
    @(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> words[slot(`SDC_IDX_1E)] == 16'h18c6;
  endproperty
  a_reset_1e: assert property (p_reset_1e) else $error("word 1e reset wrong");

  property p_reset_26;
    @(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> denominator_upper_word == 16'hffff;
  endproperty
  a_reset_26: assert property (p_reset_26) else $error("word 26 reset wrong");

  property p_soft_restore;
    @(posedge aclk) disable iff (!aresetn)
    soft_reset |=> words[slot(`SDC_IDX_18)] == 16'h071a &&
                   words[slot(`SDC_IDX_19)] == 16'h0624 &&
                   words[slot(`SDC_IDX_1F)] == 16'hc3e6 &&
                   feedback_divide_count == 19'h00028 && !pending;
  endproperty
  a_soft_restore: assert property (p_soft_restore) else $error("soft reset failed");

  property p_lower_write;
    @(posedge aclk) disable iff (!aresetn)
    bus_if.wr_en && bus_if.wr_idx == `SDC_IDX_24 && bus_if.wr_strb == 2'b11
      |=> feedback_divide_count[15:0] == $past(bus_if.wr_data);
  endproperty
  a_lower_write: assert property (p_lower_write) else $error("lower count lost");

  property p_upper_write;
    @(posedge aclk) disable iff (!aresetn)
    bus_if.wr_en && bus_if.wr_idx == `SDC_IDX_22 && bus_if.wr_strb[0]
      |=> feedback_divide_count[18:16] == $past(bus_if.wr_data[2:0]) && pending;
  endproperty
  a_upper_write: assert property (p_upper_write) else $error("upper count lost");

  property p_seed_enable;
    @(posedge aclk) disable iff (!aresetn)
    bus_if.wr_en && bus_if.wr_idx == `SDC_IDX_25 && bus_if.wr_strb[1]
      |=> fraction_seed_enable == $past(bus_if.wr_data[15]) &&
          phase_detector_delay_select == $past(bus_if.wr_data[13:8]);
  endproperty
  a_seed_enable: assert property (p_seed_enable) else $error("word 25 fields wrong");

  property p_seed_start;
    @(posedge aclk) disable iff (!aresetn)
    modulator_restart ##0 fraction_seed_enable
      |=> modulator_start_state == $past(fraction_seed_value) && seeded;
  endproperty
  a_seed_start: assert property (p_seed_start) else $error("seed not applied");

  property p_no_seed_start;
    @(posedge aclk) disable iff (!aresetn)
    modulator_restart && !fraction_seed_enable
      |=> modulator_start_state == '0 && !seeded;
  endproperty
  a_no_seed_start: assert property (p_no_seed_start) else $error("unseeded start");

  property p_delay_reset;
    @(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> phase_detector_delay_select == 6'h02 && !fraction_seed_enable;
  endproperty
  a_delay_reset: assert property (p_delay_reset) else $error("word 25 reset wrong");
endmodule : sdc_divider_config_regs

// ---- hw/sdc_regs_cfg.svh ----
// Offsets, field positions and reset values of the divider configuration bank
`ifndef SDC_REGS_CFG_SVH
`define SDC_REGS_CFG_SVH
`define SDC_IDX_CTRL       10'h000
`define SDC_IDX_STATUS     10'h001
`define SDC_IDX_18         10'h018
`define SDC_IDX_19         10'h019
`define SDC_IDX_1A         10'h01a
`define SDC_IDX_1B         10'h01b
`define SDC_IDX_1C         10'h01c
`define SDC_IDX_1D         10'h01d
`define SDC_IDX_1E         10'h01e
`define SDC_IDX_1F         10'h01f
`define SDC_IDX_20         10'h020
`define SDC_IDX_21         10'h021
`define SDC_IDX_22         10'h022
`define SDC_IDX_23         10'h023
`define SDC_IDX_24         10'h024
`define SDC_IDX_25         10'h025
`define SDC_IDX_26         10'h026
`define SDC_NUM_WORDS      15
`define SDC_RST_18         16'h071a
`define SDC_RST_19         16'h0624
`define SDC_RST_1A         16'h0808
`define SDC_RST_1B         16'h0002
`define SDC_RST_1C         16'h0488
`define SDC_RST_1D         16'h18c6
`define SDC_RST_1E         16'h18c6
`define SDC_RST_1F         16'hc3e6
`define SDC_RST_20         16'h05bf
`define SDC_RST_21         16'h1e01
`define SDC_RST_22         16'h0010
`define SDC_RST_23         16'h0004
`define SDC_RST_24         16'h0028
`define SDC_RST_25         16'h0205
`define SDC_RST_26         16'hffff
`define SDC_CTRL_RESET_BIT 0
`define SDC_UPPER_MSB      2
`define SDC_SEED_EN_BIT    15
`define SDC_DLY_MSB        13
`define SDC_DLY_LSB        8
`define SDC_RESP_OKAY      2'b00
`define SDC_RESP_SLVERR    2'b10
`endif

// ---- hw/sdc_pkg.sv ----
// Shared types of the divider configuration bank
package sdc_pkg;
  typedef logic [15:0] sdc_word_t;
  typedef logic [9:0]  sdc_idx_t;
  typedef logic [3:0]  sdc_slot_t;
  typedef enum logic [2:0] {
    SDC_WR_COLLECT = 3'b001,
    SDC_WR_COMMIT  = 3'b010,
    SDC_WR_RESP    = 3'b100
  } sdc_wr_state_t;
endpackage : sdc_pkg

// ---- hw/sdc_reg_if.sv ----
// Word access path between the bus slave and the register bank
`timescale 1ns/1ps
interface sdc_reg_if;
  logic                 wr_en;
  sdc_pkg::sdc_idx_t    wr_idx;
  sdc_pkg::sdc_word_t   wr_data;
  logic [1:0]           wr_strb;
  logic                 wr_ok;
  sdc_pkg::sdc_idx_t    rd_idx;
  sdc_pkg::sdc_word_t   rd_data;
  logic                 rd_ok;
  modport bus  (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                input  wr_ok, rd_data, rd_ok);
  modport bank (input  wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                output wr_ok, rd_data, rd_ok);
endinterface : sdc_reg_if

// ---- hw/sdc_axil_slave.sv ----
// AXI4-Lite slave that turns bus transfers into single word accesses
`timescale 1ns/1ps
`include "sdc_regs_cfg.svh"
module sdc_axil_slave #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Bank side
  sdc_reg_if.bus                 rif
);
  sdc_pkg::sdc_wr_state_t state, next_state;
  logic              aw_full, next_aw_full, w_full, next_w_full;
  sdc_pkg::sdc_idx_t aw_idx, next_aw_idx;
  logic [15:0]       w_data, next_w_data;
  logic [1:0]        w_strb, next_w_strb;
  logic [1:0]        next_bresp;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rvalid;

  ////////////////////////////////////////////////////////////////////////////
  assign awready = (state == sdc_pkg::SDC_WR_COLLECT) && !aw_full;
  assign wready  = (state == sdc_pkg::SDC_WR_COLLECT) && !w_full;
  assign bvalid  = (state == sdc_pkg::SDC_WR_RESP);
  assign rif.wr_en   = (state == sdc_pkg::SDC_WR_COMMIT);
  assign rif.wr_idx  = aw_idx;
  assign rif.wr_data = w_data;
  assign rif.wr_strb = w_strb;

  always_comb begin
    next_state  = state;
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_idx = aw_idx;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp  = bresp;
    case (state)
      sdc_pkg::SDC_WR_COLLECT: begin
        if (awvalid && awready) begin
          next_aw_full = 1'b1;
          next_aw_idx  = awaddr[11:2];
        end
        if (wvalid && wready) begin
          next_w_full = 1'b1;
          next_w_data = wdata[15:0];
          next_w_strb = wstrb[1:0];
        end
        if (next_aw_full && next_w_full) begin
          next_state = sdc_pkg::SDC_WR_COMMIT;
        end
      end
      sdc_pkg::SDC_WR_COMMIT: begin
        next_aw_full = 1'b0;
        next_w_full  = 1'b0;
        next_bresp   = rif.wr_ok ? `SDC_RESP_OKAY : `SDC_RESP_SLVERR;
        next_state   = sdc_pkg::SDC_WR_RESP;
      end
      sdc_pkg::SDC_WR_RESP: begin
        if (bready) begin
          next_state = sdc_pkg::SDC_WR_COLLECT;
        end
      end
      default: next_state = sdc_pkg::SDC_WR_COLLECT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // One read in flight; data captured from the bank on the address edge
  assign arready    = !rvalid;
  assign rif.rd_idx = araddr[11:2];

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = {16'h0000, rif.rd_data};
      next_rresp  = rif.rd_ok ? `SDC_RESP_OKAY : `SDC_RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= sdc_pkg::SDC_WR_COLLECT;
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_idx  <= 10'h000;
      w_data  <= 16'h0000;
      w_strb  <= 2'b00;
      bresp   <= `SDC_RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `SDC_RESP_OKAY;
    end else begin
      state   <= next_state;
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      aw_idx  <= next_aw_idx;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end
endmodule : sdc_axil_slave

// ---- hw/sdc_seed_engine.sv ----
// Starting state of the fractional modulator, optionally taken from the seed
`timescale 1ns/1ps
module sdc_seed_engine #(
  parameter int SEED_W = 32
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Control
  input  wire logic              restart,
  input  wire logic              seed_enable,
  input  wire logic [SEED_W-1:0] seed_value,
  // State
  output logic [SEED_W-1:0]      start_state,
  output logic                   seeded
);
  logic [SEED_W-1:0] next_start_state;
  logic              next_seeded;

  // Without the seed the engine always starts from zero
  always_comb begin
    next_start_state = start_state;
    next_seeded      = seeded;
    if (restart) begin
      next_start_state = seed_enable ? seed_value : '0;
      next_seeded      = seed_enable;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_state <= '0;
      seeded      <= 1'b0;
    end else begin
      start_state <= next_start_state;
      seeded      <= next_seeded;
    end
  end
endmodule : sdc_seed_engine

// ---- sim/sdc_host_model.sv ----
// Host model that programs the word bank over AXI4-Lite, one request at a time
`timescale 1ns/1ps
module sdc_host_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Request side
  input  wire logic        start,
  input  wire logic        is_wr,
  input  wire logic [11:0] addr,
  input  wire logic [15:0] wdat,
  output logic             done,
  output logic [31:0]      rdat,
  output logic [1:0]       resp,
  // AXI4-Lite master
  output logic [11:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [11:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic fin;
  initial begin
    {done, rdat, resp, awaddr, awvalid, wdata, wstrb, wvalid} = '0;
    {bready, araddr, arvalid, rready} = '0;
    forever begin
      @(posedge aclk);
      done <= 1'b0;
      if (start && aresetn) begin
        fin = 1'b0;
        // Whole words only, so the constants land in all sixteen bits
        if (is_wr) begin
          awaddr  <= addr;
          awvalid <= 1'b1;
          wdata   <= {16'h0000, wdat};
          wstrb   <= 4'hf;
          wvalid  <= 1'b1;
          bready  <= 1'b1;
          while (!fin) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
              resp   <= bresp;
              bready <= 1'b0;
              fin    = 1'b1;
            end
          end
        end else begin
          araddr  <= addr;
          arvalid <= 1'b1;
          rready  <= 1'b1;
          while (!fin) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
              rdat   <= rdata;
              resp   <= rresp;
              rready <= 1'b0;
              fin    = 1'b1;
            end
          end
        end
        done <= 1'b1;
      end
    end
  end
endmodule : sdc_host_model

// ---- sim/sdc_divider_config_regs_tb.sv ----
// Self-checking bench for the divider configuration word bank
`timescale 1ns/1ps
module sdc_divider_config_regs_tb;
  typedef struct packed {
    logic [9:0]  idx;
    logic [15:0] rst;
    logic [15:0] req;
  } sdc_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        start = 1'b0;
  logic        is_wr = 1'b0;
  logic [11:0] addr = '0;
  logic [15:0] wdat = '0;
  logic        done;
  logic [31:0] rdat;
  logic [1:0]  resp;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed = 32'h0000_0000, start_state;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, restart = 1'b0;
  logic [18:0] count;
  logic [5:0]  dly;
  logic        seed_en;
  logic [15:0] den;
  int          err_count = 0;
  int          cmp_count = 0;
  // Required value beside reset value; 0x22, 0x24, 0x25, 0x26 carry test settings
  sdc_row_t rows [15] = '{
    '{10'h018, 16'h071a, 16'h071a}, '{10'h019, 16'h0624, 16'h0624},
    '{10'h01a, 16'h0808, 16'h0808}, '{10'h01b, 16'h0002, 16'h0002},
    '{10'h01c, 16'h0488, 16'h0488}, '{10'h01d, 16'h18c6, 16'h0000},
    '{10'h01e, 16'h18c6, 16'h18a6}, '{10'h01f, 16'hc3e6, 16'hc3e6},
    '{10'h020, 16'h05bf, 16'h05bf}, '{10'h021, 16'h1e01, 16'h1e01},
    '{10'h022, 16'h0010, 16'h0012}, '{10'h023, 16'h0004, 16'h0004},
    '{10'h024, 16'h0028, 16'h1234}, '{10'h025, 16'h0205, 16'h8a05},
    '{10'h026, 16'hffff, 16'h5a5a}};

  always #5 aclk = ~aclk;

  sdc_host_model sdc_host_model_inst (.aclk(aclk), .aresetn(aresetn), .start(start),
    .is_wr(is_wr), .addr(addr), .wdat(wdat), .done(done), .rdat(rdat), .resp(resp),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  sdc_divider_config_regs sdc_divider_config_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .modulator_restart(restart),
    .fraction_seed_value(seed), .modulator_start_state(start_state),
    .feedback_divide_count(count), .phase_detector_delay_select(dly),
    .fraction_seed_enable(seed_en), .denominator_upper_word(den));

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One bus request through the host model, bounded wait on its completion
  task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d);
    int n;
    @(posedge aclk);
    start <= 1'b1;
    is_wr <= w;
    addr  <= {idx, 2'b00};
    wdat  <= d;
    @(posedge aclk);
    start <= 1'b0;
    for (n = 0; n < 50 && done !== 1'b1; n++) @(posedge aclk);
    if (done !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask : bus

  task automatic pulse_restart(input logic [31:0] s);
    @(posedge aclk);
    seed    <= s;
    restart <= 1'b1;
    @(posedge aclk);
    restart <= 1'b0;
    @(posedge aclk);
  endtask : pulse_restart

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({13'h0, count}, 32'h0000_0028);
    check({26'h0, dly}, 32'h0000_0002);
    check({31'h0, seed_en}, 32'h0000_0000);
    check({16'h0, den}, 32'h0000_ffff);
    $display("test reset outputs done");
    foreach (rows[i]) begin
      bus(1'b0, rows[i].idx, 16'h0000);
      check(rdat, {16'h0, rows[i].rst});
      check({30'h0, resp}, 32'h0000_0000);
      bus(1'b1, rows[i].idx, rows[i].req);
      bus(1'b0, rows[i].idx, 16'h0000);
      check(rdat, {16'h0, rows[i].req});
    end
    $display("test word table done");
    check({13'h0, count}, 32'h0002_1234);
    check({26'h0, dly}, 32'h0000_000a);
    check({31'h0, seed_en}, 32'h0000_0001);
    check({16'h0, den}, 32'h0000_5a5a);
    pulse_restart(32'h5a5a_c3c3);
    check(start_state, 32'h5a5a_c3c3);
    // Upper half alone leaves the count pair marked as half written
    bus(1'b1, 10'h022, 16'h0012);
    bus(1'b0, 10'h001, 16'h0000);
    check(rdat, 32'h0000_0003);
    bus(1'b1, 10'h025, 16'h0205);
    check({31'h0, seed_en}, 32'h0000_0000);
    pulse_restart(32'h1111_2222);
    check(start_state, 32'h0000_0000);
    $display("test seed done");
    bus(1'b0, 10'h3ff, 16'h0000);
    check({30'h0, resp}, 32'h0000_0002);
    check(rdat, 32'h0000_0000);
    bus(1'b1, 10'h3ff, 16'h1234);
    check({30'h0, resp}, 32'h0000_0002);
    bus(1'b1, 10'h001, 16'h0003);
    check({30'h0, resp}, 32'h0000_0002);
    $display("test unmapped done");
    bus(1'b1, 10'h000, 16'h0001);
    check({30'h0, resp}, 32'h0000_0000);
    check({13'h0, count}, 32'h0000_0028);
    check({16'h0, den}, 32'h0000_ffff);
    bus(1'b0, 10'h001, 16'h0000);
    check(rdat, 32'h0000_0000);
    bus(1'b0, 10'h01e, 16'h0000);
    check(rdat, 32'h0000_18c6);
    bus(1'b0, 10'h01d, 16'h0000);
    check(rdat, 32'h0000_18c6);
    $display("test soft reset done");
    // Bus reset in mid-run, with a non-default count standing
    bus(1'b1, 10'h024, 16'h4321);
    check({13'h0, count}, 32'h0000_4321);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({13'h0, count}, 32'h0000_0028);
    check({26'h0, dly}, 32'h0000_0002);
    check({16'h0, den}, 32'h0000_ffff);
    bus(1'b0, 10'h01e, 16'h0000);
    check(rdat, 32'h0000_18c6);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : sdc_divider_config_regs_tb
